// File: pkg/ris_pkg.sv
// Package: constants and types for the reset initialization sequencer
package ris_pkg;

  // Minimum assertion of an external reset input, in bus clock periods
  localparam int unsigned RIS_IN_ASSERT_MIN = 32;
  // Minimum power-on reset assertion, in primary clock periods
  localparam int unsigned RIS_POR_ASSERT_MIN = 32;
  // Reset output assertion, in bus clock periods
  localparam int unsigned RIS_OUT_ASSERT = 512;
  // Hard to soft reset release stagger, in bus clock periods
  localparam int unsigned RIS_SOFT_STAGGER = 16;
  // Delay before straps are driven again, in bus clock periods
  localparam int unsigned RIS_STRAP_RESUME = 1;
  // Strap setup before power-on release, in periods
  localparam int unsigned RIS_STRAP_SETUP = 4;
  // DLL lock window in system bus clock cycles
  localparam int unsigned RIS_DLL_LOCK_MIN = 7680;
  localparam int unsigned RIS_DLL_LOCK_MAX = 122880;
  // Width of the reset source strap
  localparam int unsigned RIS_SRC_W = 3;
  // Width of the shared sequencing counter
  localparam int unsigned RIS_CNT_W = 18;

  // Sequencer states
  typedef enum logic [2:0] {
    RIS_POR,
    RIS_PLL_WAIT,
    RIS_DLL_WAIT,
    RIS_HOLD,
    RIS_STAGGER,
    RIS_RUN
  } ris_state_t;

endpackage

// File: design/ris_bus_tick.sv
// Bus clock tick generator: one pulse per divided period in host mode, per synchronised bus clock period as agent
`timescale 1ns/10ps
module ris_bus_tick #(
  parameter int unsigned DIV_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic host_mode_i,
  input wire logic [DIV_W-1:0] divide_i,
  input wire logic bus_clk_i,
  output logic tick_o
);

  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic meta_q, sync_q, prev_q;
  logic tick_d, tick_q;

  // Two-stage synchroniser and edge history of the agent bus clock
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= bus_clk_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (host_mode_i) begin
      if (cnt_q >= divide_i) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end else begin
      cnt_d = '0;
      tick_d = sync_q & ~prev_q;
    end
  end

  // Divider and tick registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// File: design/ris_sequencer.sv
// Reset initialization sequencer top level
`timescale 1ns/10ps
module ris_sequencer #(
  parameter int unsigned DIV_W = 4,
  parameter int unsigned OUT_ASSERT = ris_pkg::RIS_OUT_ASSERT,
  parameter int unsigned SOFT_STAGGER = ris_pkg::RIS_SOFT_STAGGER,
  parameter int unsigned DLL_LOCK_MIN = ris_pkg::RIS_DLL_LOCK_MIN,
  parameter int unsigned DLL_LOCK_MAX = ris_pkg::RIS_DLL_LOCK_MAX
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic hard_reset_n_i,
  input wire logic soft_reset_n_i,
  input wire logic host_strap_i,
  input wire logic bus_clk_i,
  input wire logic [DIV_W-1:0] clock_divide_strap_i,
  input wire logic [ris_pkg::RIS_SRC_W-1:0] reset_source_strap_i,
  input wire logic pll_lock_i,
  input wire logic dll_lock_i,
  output logic hard_reset_n_o,
  output logic hard_reset_n_oe_o,
  output logic soft_reset_n_o,
  output logic soft_reset_n_oe_o,
  output logic strap_oe_o,
  output logic internal_reset_o,
  output logic dll_timeout_o,
  output logic host_mode_o,
  output logic [DIV_W-1:0] clock_divide_o,
  output logic [ris_pkg::RIS_SRC_W-1:0] reset_source_o
);
  import ris_pkg::*;

  localparam int unsigned IN_W = $clog2(RIS_IN_ASSERT_MIN + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [5:0] meta_q, sync_q;
  logic por_n_s, hrst_n_s, srst_n_s, host_s, pll_s, dll_s;

  // Two flops on every asynchronous pin
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {power_on_reset_n_i, hard_reset_n_i, soft_reset_n_i,
                 host_strap_i, pll_lock_i, dll_lock_i};
      sync_q <= meta_q;
    end
  end
  assign {por_n_s, hrst_n_s, srst_n_s, host_s, pll_s, dll_s} = sync_q;

  logic [DIV_W-1:0] div_meta_q, div_sync_q;
  logic [RIS_SRC_W-1:0] src_meta_q, src_sync_q;

  // Strap bus synchronisers, stable while power-on reset is low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_meta_q <= '0;
      div_sync_q <= '0;
      src_meta_q <= '0;
      src_sync_q <= '0;
    end else begin
      div_meta_q <= clock_divide_strap_i;
      div_sync_q <= div_meta_q;
      src_meta_q <= reset_source_strap_i;
      src_sync_q <= src_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture at power-on release
  logic host_q, host_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [RIS_SRC_W-1:0] src_q, src_d;

  always_comb begin
    host_d = host_q;
    div_d = div_q;
    src_d = src_q;
    if (!por_n_s) begin
      host_d = host_s;
      div_d = div_sync_q;
      src_d = src_sync_q;
    end
  end

  // Strap registers, frozen once power-on reset is released
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_q <= 1'b0;
      div_q <= '0;
      src_q <= '0;
    end else begin
      host_q <= host_d;
      div_q <= div_d;
      src_q <= src_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock period tick
  logic tick;

  ris_bus_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .host_mode_i(host_q),
    .divide_i(div_q),
    .bus_clk_i(bus_clk_i),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // External reset request filter
  ris_state_t state_q, state_d;
  logic [IN_W-1:0] in_cnt_q, in_cnt_d;
  logic [1:0] busy_q, busy_d;
  logic ext_req;

  // count qualifying assertion
  // Counted only in RUN, and only once the synchronised pins have caught
  // up with the release of our own drive, so we never retrigger ourselves
  always_comb begin
    in_cnt_d = in_cnt_q;
    busy_d = {busy_q[0], state_q != RIS_RUN};
    if ((hrst_n_s && srst_n_s) || state_q != RIS_RUN ||
        busy_q != 2'h0) begin
      in_cnt_d = '0;
    end else if (tick && in_cnt_q < IN_W'(RIS_IN_ASSERT_MIN)) begin
      in_cnt_d = in_cnt_q + 1'b1;
    end
  end
  assign ext_req = (in_cnt_q >= IN_W'(RIS_IN_ASSERT_MIN));

  // Input assertion counter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      in_cnt_q <= '0;
      busy_q <= 2'h3;
    end else begin
      in_cnt_q <= in_cnt_d;
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer
  logic [RIS_CNT_W-1:0] cnt_q, cnt_d;
  logic irst_q, irst_d;
  logic hrst_q, hrst_d, srst_q, srst_d;
  logic strap_oe_q, strap_oe_d;
  logic [1:0] resume_q, resume_d;
  logic tmo_q, tmo_d;

  // State transitions and reset output drive
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hrst_d = hrst_q;
    srst_d = srst_q;
    tmo_d = tmo_q;
    unique case (state_q)
      RIS_POR: begin
        hrst_d = 1'b1;
        srst_d = 1'b1;
        cnt_d = '0;
        if (por_n_s) begin
          state_d = RIS_PLL_WAIT;
        end
      end
      RIS_PLL_WAIT: begin
        if (pll_s) begin
          state_d = RIS_DLL_WAIT;
        end
      end
      RIS_DLL_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if ((dll_s && cnt_q >= RIS_CNT_W'(DLL_LOCK_MIN)) ||
            cnt_q >= RIS_CNT_W'(DLL_LOCK_MAX)) begin
          tmo_d = !dll_s;
          cnt_d = '0;
          state_d = RIS_HOLD;
        end
      end
      RIS_HOLD: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        // One tick beyond the count: a hold begun mid-period still spans
        // the full number of bus clock periods
        if (cnt_q > RIS_CNT_W'(OUT_ASSERT)) begin
          hrst_d = 1'b0;
          cnt_d = '0;
          state_d = RIS_STAGGER;
        end
      end
      RIS_STAGGER: begin
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cnt_q >= RIS_CNT_W'(SOFT_STAGGER)) begin
          srst_d = 1'b0;
          state_d = RIS_RUN;
        end
      end
      RIS_RUN: begin
        if (ext_req) begin
          hrst_d = 1'b1;
          srst_d = 1'b1;
          cnt_d = '0;
          state_d = RIS_HOLD;
        end
      end
    endcase
    if (!por_n_s) begin
      state_d = RIS_POR;
      hrst_d = 1'b1;
      srst_d = 1'b1;
      cnt_d = '0;
    end
    // Internal reset follows the next state so it leaves a flop
    irst_d = (state_d == RIS_POR) || (state_d == RIS_PLL_WAIT) ||
             (state_d == RIS_DLL_WAIT);
  end

  always_comb begin
    strap_oe_d = strap_oe_q;
    resume_d = resume_q;
    if (hrst_d || !hrst_n_s) begin
      strap_oe_d = 1'b0;
      resume_d = '0;
    end else if (!strap_oe_q && tick) begin
      if (resume_q >= 2'(RIS_STRAP_RESUME)) begin
        strap_oe_d = 1'b1;
      end else begin
        resume_d = resume_q + 1'b1;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= RIS_POR;
      cnt_q <= '0;
      hrst_q <= 1'b1;
      srst_q <= 1'b1;
      strap_oe_q <= 1'b0;
      resume_q <= '0;
      tmo_q <= 1'b0;
      irst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hrst_q <= hrst_d;
      srst_q <= srst_d;
      strap_oe_q <= strap_oe_d;
      resume_q <= resume_d;
      tmo_q <= tmo_d;
      irst_q <= irst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // open-drain, data always low
  assign hard_reset_n_o = 1'b0;
  assign soft_reset_n_o = 1'b0;
  assign hard_reset_n_oe_o = hrst_q;
  assign soft_reset_n_oe_o = srst_q;
  assign strap_oe_o = strap_oe_q;
  assign internal_reset_o = irst_q;
  assign dll_timeout_o = tmo_q;
  assign host_mode_o = host_q;
  assign clock_divide_o = div_q;
  assign reset_source_o = src_q;

endmodule

// File: verif/ris_sequencer_checker.sv
// Port checker of the reset sequencer
`timescale 1ns/10ps
module ris_checker #(
  parameter int unsigned OUT_ASSERT = 8,
  parameter int unsigned SOFT_STAGGER = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic pll_lock_i,
  input wire logic hard_reset_n_o,
  input wire logic hard_reset_n_oe_o,
  input wire logic soft_reset_n_o,
  input wire logic soft_reset_n_oe_o,
  input wire logic strap_oe_o,
  input wire logic internal_reset_o
);
  logic [19:0] hold_q, hold_d, stag_q, stag_d;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles of hold and of the soft release stagger
  always_comb begin
    hold_d = (internal_reset_o || !hard_reset_n_oe_o) ? '0 : hold_q + 1'b1;
    stag_d = hard_reset_n_oe_o ? '0 : stag_q + {19'h0, soft_reset_n_oe_o};
  end
  always_ff @(posedge clk_sys_i) begin
    hold_q <= rst_i ? '0 : hold_d;
    stag_q <= rst_i ? '0 : stag_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_od_low;
    !hard_reset_n_o && !soft_reset_n_o;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("reset pin data not low");
  property p_order;
    hard_reset_n_oe_o |-> soft_reset_n_oe_o;
  endproperty
  a_order: assert property (p_order)
    else $error("soft released before hard");
  property p_hold;
    $fell(hard_reset_n_oe_o) |-> hold_q >= OUT_ASSERT;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hard reset hold too short");
  property p_stag;
    $fell(soft_reset_n_oe_o) |-> stag_q >= SOFT_STAGGER;
  endproperty
  a_stag: assert property (p_stag)
    else $error("soft stagger too short");
  property p_strap_off;
    $rose(hard_reset_n_oe_o) |-> !strap_oe_o;
  endproperty
  a_strap_off: assert property (p_strap_off)
    else $error("straps driven at hard reset");
  property p_strap_on;
    $rose(strap_oe_o) |-> !hard_reset_n_oe_o && !$past(hard_reset_n_oe_o);
  endproperty
  a_strap_on: assert property (p_strap_on)
    else $error("straps driven too early");
  property p_pll;
    $fell(internal_reset_o) |-> pll_lock_i;
  endproperty
  a_pll: assert property (p_pll)
    else $error("internal reset left without lock");
  property p_por;
    !power_on_reset_n_i |->
      ##[1:4] (internal_reset_o && hard_reset_n_oe_o && soft_reset_n_oe_o);
  endproperty
  a_por: assert property (p_por)
    else $error("power-on reset not applied");
endmodule

bind ris_sequencer ris_checker #(
  .OUT_ASSERT(OUT_ASSERT), .SOFT_STAGGER(SOFT_STAGGER)
) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pll_lock_i(pll_lock_i),
  .power_on_reset_n_i(power_on_reset_n_i), .hard_reset_n_o(hard_reset_n_o),
  .hard_reset_n_oe_o(hard_reset_n_oe_o), .soft_reset_n_o(soft_reset_n_o),
  .soft_reset_n_oe_o(soft_reset_n_oe_o), .strap_oe_o(strap_oe_o),
  .internal_reset_o(internal_reset_o)
);

// File: verif/ris_board.sv
// Board model: reset sources, pulled-up reset wires, bus clock, locks
`timescale 1ns/10ps
module ris_board (
  input wire logic clk_sys_i,
  input wire logic por_req_i,
  input wire logic hard_req_i,
  input wire logic soft_req_i,
  input wire logic pll_go_i,
  input wire logic dll_ok_i,
  input wire logic hard_oe_i,
  input wire logic soft_oe_i,
  output logic por_n_o,
  output logic hard_n_o,
  output logic soft_n_o,
  output logic bus_clk_o,
  output logic pll_lock_o,
  output logic dll_lock_o
);
  logic [1:0] cnt_q = 2'h0, cnt_d;
  logic bclk_q = 1'b0, bclk_d;
  assign por_n_o = !por_req_i;
  assign hard_n_o = !(hard_oe_i || hard_req_i);
  assign soft_n_o = !(soft_oe_i || soft_req_i);
  // Lock indications
  assign pll_lock_o = pll_go_i;
  assign dll_lock_o = pll_go_i && dll_ok_i;
  always_comb begin
    cnt_d = cnt_q + 2'h1;
    bclk_d = (cnt_q == 2'h3) ? !bclk_q : bclk_q;
  end
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= cnt_d;
    bclk_q <= bclk_d;
  end
  assign bus_clk_o = bclk_q;
endmodule

// File: verif/testbench.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/10ps
module testbench;
  import ris_pkg::*;
  localparam int OUT = 8;
  localparam int STG = 2;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, por_req = 1'b1, hard_req = 1'b0;
  logic soft_req = 1'b0, pll_go = 1'b0, dll_ok = 1'b0, host = 1'b1;
  logic [3:0] div = 4'h0;
  logic [2:0] src = 3'h0;
  logic por_n, hard_n, soft_n, bclk, pll, dll, h_oe, s_oe, st_oe, irst;
  logic dto, hm;
  logic [3:0] cdiv;
  logic [2:0] rsrc;
  int fail_count = 0, check_count = 0;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  ris_sequencer #(
    .DIV_W(4), .OUT_ASSERT(OUT), .SOFT_STAGGER(STG), .DLL_LOCK_MIN(4),
    .DLL_LOCK_MAX(16)
  ) DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_on_reset_n_i(por_n),
    .hard_reset_n_i(hard_n), .soft_reset_n_i(soft_n), .host_strap_i(host),
    .bus_clk_i(bclk), .clock_divide_strap_i(div), .reset_source_strap_i(src),
    .pll_lock_i(pll), .dll_lock_i(dll), .hard_reset_n_o(),
    .hard_reset_n_oe_o(h_oe), .soft_reset_n_o(), .soft_reset_n_oe_o(s_oe),
    .strap_oe_o(st_oe), .internal_reset_o(irst), .dll_timeout_o(dto),
    .host_mode_o(hm), .clock_divide_o(cdiv), .reset_source_o(rsrc)
  );
  ris_board u_brd (
    .clk_sys_i(clk_sys_i), .por_req_i(por_req), .hard_req_i(hard_req),
    .soft_req_i(soft_req), .pll_go_i(pll_go), .dll_ok_i(dll_ok),
    .hard_oe_i(h_oe), .soft_oe_i(s_oe), .por_n_o(por_n), .hard_n_o(hard_n),
    .soft_n_o(soft_n), .bus_clk_o(bclk), .pll_lock_o(pll), .dll_lock_o(dll)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? irst : k == 1 ? h_oe : s_oe;
  endfunction
  // Bounded wait for an output level, counting edges
  task automatic wt(input int k, input logic v, output int n);
    n = 0;
    #1;
    while (sig(k) !== v) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > 2000) begin
        fail_count++;
        summarize();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Power-on flow with mode, divide, source, DLL outcome, tick period
  task automatic t_boot(input logic h, input logic [3:0] d,
                        input logic [2:0] s, input logic ok, input int per);
    int n, r, w;
    @(posedge clk_sys_i);
    por_req <= 1'b1;
    pll_go <= 1'b0;
    dll_ok <= ok;
    host <= h;
    div <= d;
    src <= s;
    cyc(40 * per);
    por_req <= 1'b0;
    cyc(20);
    #1;
    check(irst, 1'b1);
    check({hm, cdiv, rsrc}, {h, d, s});
    cyc(1);
    pll_go <= 1'b1;
    wt(0, 1'b0, n);
    check(ok ? n >= 4 && n <= 12 : n >= 16 && n <= 24, 1'b1);
    check(dto, !ok);
    wt(1, 1'b0, n);
    check(n >= (OUT - 1) * per && n <= (OUT + 1) * per + 4, 1'b1);
    r = 0;
    w = 0;
    for (int i = 1; i < 8 * per && (r == 0 || w == 0); i++) begin
      @(posedge clk_sys_i);
      #1;
      if (r == 0 && st_oe === 1'b1) r = i;
      if (w == 0 && s_oe === 1'b0) w = i;
    end
    check(w >= STG * per && w <= STG * per + 2, 1'b1);
    check(r >= per && r <= 2 * per + 2, 1'b1);
  endtask
  // Short and long external hard and soft pulls while running
  task automatic t_ext();
    int n;
    logic seen;
    for (int i = 0; i < 4; i++) begin
      seen = 1'b0;
      @(posedge clk_sys_i);
      hard_req <= i[0];
      soft_req <= !i[0];
      repeat (i < 2 ? 20 : 40) begin
        @(posedge clk_sys_i);
        #1;
        seen |= h_oe;
      end
      if (i[0]) check(st_oe, 1'b0);
      @(posedge clk_sys_i);
      hard_req <= 1'b0;
      soft_req <= 1'b0;
      wt(2, 1'b0, n);
      check(seen, i >= 2);
      cyc(5);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_i <= 1'b0;
    #1;
    check({h_oe, s_oe, st_oe, irst, dto, hm, cdiv, rsrc}, 13'h1A00);
    t_boot(1'b1, 4'h0, 3'h5, 1'b1, 1);
    t_ext();
    t_boot(1'b1, 4'h2, 3'h2, 1'b0, 3);
    t_boot(1'b0, 4'h1, 3'h7, 1'b1, 8);
    summarize();
  end
endmodule
